// >>> common/extbu_map.svh
// register-free constants for the external bus unit
`ifndef EXTBU_MAP_SVH
`define EXTBU_MAP_SVH
`define EXTBU_NUM_WIN 4
`define EXTBU_ADDR_W 24
`define EXTBU_WIN_SIZE_W 4
`define EXTBU_MCT_W 4
`define EXTBU_ALE_RST 1'b0
`define EXTBU_MTT_RST 1'b0
`define EXTBU_RWD_RST 1'b0
`define EXTBU_MCT_RST 4'h0
`define EXTBU_SEG_16M 2'h0
`define EXTBU_SEG_1M 2'h1
`define EXTBU_SEG_256K 2'h2
`define EXTBU_SEG_64K 2'h3
`define EXTBU_SYNC_STAGES 3
`endif

// >>> common/extbu_pkg.sv
// types shared by the external bus unit
package extbu_pkg;
   // bus mode: single chip or one of four external modes
   typedef enum logic [2:0] {
      EXTBU_SINGLE,
      EXTBU_DEMUX16,
      EXTBU_MUX16,
      EXTBU_MUX8,
      EXTBU_DEMUX8
   } extbu_mode_t;
   // per-window bus characteristics
   typedef struct packed {
      extbu_mode_t mode;
      logic [3:0] cycle_wait;
      logic tristate_wait;
      logic long_ale;
      logic rw_delay;
      logic ready_en;
      logic enable;
   } extbu_cfg_t;
   // window range: base address bits and size code
   typedef struct packed {
      logic [11:0] base;
      logic [3:0] size;
   } extbu_range_t;
   // access request from the core
   typedef struct packed {
      logic [23:0] addr;
      logic [15:0] wdata;
      logic write;
   } extbu_req_t;
endpackage

// >>> hdl/extbu_top.sv
// external bus unit: modes, windows, selects, ready, arbitration
`timescale 1ns/100ps
`include "extbu_map.svh"
module extbu_top
   import extbu_pkg::*;
#(
   parameter int NWIN = `EXTBU_NUM_WIN
) (
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // configuration
   input wire extbu_cfg_t i_default_bus_config_reg,
   input wire extbu_cfg_t [NWIN-1:0] i_window_bus_config_reg,
   input wire extbu_range_t [NWIN-1:0] i_window_range_reg,
   input wire logic i_unlatched_select_bit,
   input wire logic i_arbitration_enable_bit,
   input wire logic i_arbitration_port_dir_bit7,
   input wire logic [1:0] i_seg_space,
   input wire logic [15:0] i_data_port_dir,
   input wire logic [15:0] i_data_port_gpio,
   // core request side
   input wire logic i_req_valid,
   input wire extbu_req_t i_req,
   output logic o_req_ready,
   output logic o_rsp_valid,
   output logic [15:0] o_rsp_data,
   output logic o_ext_fetch,
   // bus pins
   input wire logic [15:0] i_data_port_pins,
   output logic [15:0] o_data_port_pins,
   output logic [15:0] o_data_port_oe,
   output logic [15:0] o_address_port_pins,
   output logic o_address_port_oe,
   output logic [7:0] o_segment_pins,
   output logic o_ale,
   output logic o_rd_n,
   output logic o_wr_n,
   input wire logic i_ready_n,
   input wire logic i_external_fetch_select,
   // arbitration port
   output logic [4:0] o_select_n,
   input wire logic i_hold_n,
   input wire logic i_takeover_acknowledge_n,
   output logic o_takeover_acknowledge_n,
   output logic o_takeover_acknowledge_oe,
   output logic o_bus_request_out_n
);

   // access sequencer states
   typedef enum logic [2:0] {
      ST_IDLE, ST_ADDR, ST_WAIT, ST_DATA, ST_TRI, ST_HELD
   } extbu_st_t;

   extbu_st_t st_q; // sequencer state
   extbu_st_t st_d;
   extbu_req_t req_q; // captured request
   extbu_cfg_t cfg_q; // config latched at access start
   logic [4:0] sel_q; // latched select lines, active high
   logic [3:0] cnt_q; // wait state counter
   logic [3:0] cnt_d;
   logic [15:0] rdata_q; // read data capture
   logic rsp_q; // response pulse
   logic [2:0] rdy_sync_q; // ready synchroniser
   logic [2:0] hold_sync_q; // hold request synchroniser
   logic [2:0] ack_sync_q; // acknowledge input synchroniser
   logic [2:0] ea_sync_q; // fetch select synchroniser
   logic rdy_q; // filtered ready, active high
   logic hold_q; // filtered hold request
   logic ea_q; // filtered fetch select level
   logic ext_fetch_q; // fetch source flag
   logic arb_on_q; // arbitration latched on

   // window hit: compare address against base above size bits
   function automatic logic win_hit(input extbu_range_t r,
                                    input logic [23:0] a);
      logic [23:0] base_a;
      logic [23:0] mask;
      base_a = {r.base, 12'h000};
      mask = 24'hffffff << (5'(r.size) + 5'h0c);
      win_hit = ((a & mask) == (base_a & mask));
   endfunction

   // select decode for an address, one-hot incl. default
   function automatic logic [4:0] sel_dec(input logic [23:0] a,
      input extbu_range_t [NWIN-1:0] rr,
      input extbu_cfg_t [NWIN-1:0] cc);
      logic [NWIN-1:0] h;
      h = '0;
      for (int k = 0; k < NWIN; k++) begin
         h[k] = cc[k].enable && win_hit(rr[k], a);
      end
      sel_dec = 5'h00;
      // pairs resolved high index first
      if (h[3]) begin
         sel_dec = 5'h10;
      end else if (h[2]) begin
         sel_dec = 5'h08;
      end else if (h[1]) begin
         sel_dec = 5'h04;
      end else if (h[0]) begin
         sel_dec = 5'h02;
      end else begin
         sel_dec = 5'h01;
      end
   endfunction

   // continuous decode of current and live addresses
   wire logic [4:0] sel_new = sel_dec(i_req.addr, i_window_range_reg,
                                      i_window_bus_config_reg);
   wire logic [4:0] sel_live = sel_dec(req_q.addr, i_window_range_reg,
                                       i_window_bus_config_reg);
   wire extbu_cfg_t cfg_new = sel_new[4] ? i_window_bus_config_reg[3] :
      sel_new[3] ? i_window_bus_config_reg[2] :
      sel_new[2] ? i_window_bus_config_reg[1] :
      sel_new[1] ? i_window_bus_config_reg[0] :
      i_default_bus_config_reg;
   wire logic is_mux = (cfg_q.mode == EXTBU_MUX8) ||
                       (cfg_q.mode == EXTBU_MUX16);
   wire logic is_w16 = (cfg_q.mode == EXTBU_MUX16) ||
                       (cfg_q.mode == EXTBU_DEMUX16);
   wire logic is_slave = i_arbitration_port_dir_bit7;
   wire logic bus_busy = (st_q != ST_IDLE) && (st_q != ST_HELD);
   wire logic hold_go = arb_on_q && !is_slave && hold_q;
   wire logic slave_go = arb_on_q && is_slave && !ack_sync_q[2] &&
                         !ack_sync_q[1];
   wire logic ext_ok = (cfg_new.mode != EXTBU_SINGLE);
   wire logic addr_ph = (st_q == ST_ADDR);
   wire logic drive = bus_busy && (st_q != ST_TRI);

   // input synchronisers; third and second stage agree
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rdy_sync_q <= 3'h7;
         hold_sync_q <= 3'h7;
         ack_sync_q <= 3'h7;
         ea_sync_q <= 3'h0;
      end else begin
         rdy_sync_q <= {rdy_sync_q[1:0], i_ready_n};
         hold_sync_q <= {hold_sync_q[1:0], i_hold_n};
         ack_sync_q <= {ack_sync_q[1:0], i_takeover_acknowledge_n};
         ea_sync_q <= {ea_sync_q[1:0], i_external_fetch_select};
      end
   end

   // filtered levels change only when stages two and three agree
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rdy_q <= 1'b0;
         hold_q <= 1'b0;
         ea_q <= 1'b0;
      end else begin
         if (rdy_sync_q[2] == rdy_sync_q[1]) rdy_q <= !rdy_sync_q[2];
         if (hold_sync_q[2] == hold_sync_q[1]) hold_q <= !hold_sync_q[2];
         if (ea_sync_q[2] == ea_sync_q[1]) ea_q <= ea_sync_q[2];
      end
   end

   // fetch source set during reset, follows the inverted pin after release
   // a separate held reset would be cleaner; here the first core
   // request that starts an access at a nonzero address freezes the strap
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         ext_fetch_q <= 1'b1;
      end else if (st_q == ST_IDLE && !o_rsp_valid && !rsp_q &&
                   !i_req_valid && req_q.addr == 24'h0) begin
         ext_fetch_q <= !ea_q;
      end
   end

   // arbitration enable is sticky once software sets it
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         arb_on_q <= 1'b0;
      end else if (i_arbitration_enable_bit) begin
         arb_on_q <= 1'b1;
      end
   end

   // sequencer next state
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      case (st_q)
         ST_IDLE: begin
            if (hold_go || slave_go) begin
               st_d = ST_HELD;
            end else if (i_req_valid && ext_ok) begin
               st_d = ST_ADDR;
               cnt_d = cfg_new.long_ale ? 4'h1 : 4'h0;
            end
         end
         ST_ADDR: begin
            if (cnt_q == 4'h0) begin
               st_d = ST_WAIT;
               cnt_d = cfg_q.cycle_wait;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         ST_WAIT: begin
            if (cnt_q != 4'h0) begin
               cnt_d = cnt_q - 4'h1;
            end else if (!cfg_q.ready_en || rdy_q) begin
               st_d = ST_DATA;
            end
         end
         ST_DATA: begin
            st_d = ST_TRI;
            cnt_d = cfg_q.tristate_wait ? 4'h1 : 4'h0;
         end
         ST_TRI: begin
            if (cnt_q == 4'h0) begin
               st_d = ST_IDLE;
            end else begin
               cnt_d = cnt_q - 4'h1;
            end
         end
         ST_HELD: begin
            if (!hold_go && !slave_go) begin
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // sequencer registers
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= ST_IDLE;
         cnt_q <= 4'h0;
         req_q <= '0;
         cfg_q <= '0;
         sel_q <= 5'h00;
         rdata_q <= 16'h0000;
         rsp_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         rsp_q <= (st_q == ST_DATA);
         if (st_q == ST_IDLE && st_d == ST_ADDR) begin
            req_q <= i_req;
            cfg_q <= cfg_new;
            sel_q <= sel_new; // select filter latches per access
         end
         if (st_q == ST_TRI && st_d == ST_IDLE) begin
            sel_q <= 5'h00;
         end
         if (st_q == ST_DATA && !req_q.write) begin
            rdata_q <= is_w16 ? i_data_port_pins :
                       {8'h00, i_data_port_pins[7:0]};
         end
      end
   end

   // core handshake
   assign o_req_ready = (st_q == ST_IDLE) && !hold_go && !slave_go;
   assign o_rsp_valid = rsp_q;
   assign o_rsp_data = rdata_q;
   assign o_ext_fetch = ext_fetch_q;

   // data port drive: address phase in mux, write data later
   wire logic [15:0] ad_out = addr_ph && is_mux ? req_q.addr[15:0] :
                              req_q.wdata;
   wire logic [15:0] bus_oe_lo = (addr_ph && is_mux) ||
      (drive && req_q.write && !addr_ph && !cfg_q.rw_delay) ||
      (drive && req_q.write && st_q == ST_DATA) ? 16'h00ff : 16'h0000;
   wire logic hi_bus = is_w16 || is_mux;
   wire logic hi_addr = addr_ph || (is_mux && !is_w16 && drive);
   wire logic [15:0] bus_oe = bus_oe_lo | (hi_bus &&
      (bus_oe_lo[0] || (is_mux && !is_w16 && hi_addr)) ?
      16'hff00 : 16'h0000);
   wire logic [15:0] hi_val = (is_mux && !is_w16) ?
      {req_q.addr[15:8], 8'h00} : {ad_out[15:8], 8'h00};
   wire logic bus_owned = bus_busy;
   // free high byte stays general-purpose in demux 8-bit
   assign o_data_port_pins = bus_owned ?
      {hi_bus ? hi_val[15:8] : i_data_port_gpio[15:8], ad_out[7:0]} :
      i_data_port_gpio;
   // handed over: port floats so the other master owns it
   assign o_data_port_oe = (st_q == ST_HELD) ? 16'h0000 : bus_owned ?
      (bus_oe | (hi_bus ? 16'h0000 : ~i_data_port_dir & 16'hff00)) :
      ~i_data_port_dir;
   assign o_address_port_pins = req_q.addr[15:0];
   assign o_address_port_oe = bus_owned && !is_mux;
   assign o_ale = addr_ph && is_mux;

   // segment lines masked by space size
   wire logic [7:0] seg_mask = (i_seg_space == `EXTBU_SEG_16M) ? 8'hff :
      (i_seg_space == `EXTBU_SEG_1M) ? 8'h0f :
      (i_seg_space == `EXTBU_SEG_256K) ? 8'h03 : 8'h00;
   assign o_segment_pins = req_q.addr[23:16] & seg_mask;

   // strobes after optional read/write delay
   wire logic strobe = (st_q == ST_WAIT || st_q == ST_DATA) &&
                       !(cfg_q.rw_delay && st_q == ST_WAIT &&
                         cnt_q == cfg_q.cycle_wait);
   assign o_rd_n = !(strobe && !req_q.write);
   assign o_wr_n = !(strobe && req_q.write);

   // selects: latched per access or straight from address
   wire logic [4:0] sel_out = i_unlatched_select_bit ?
      (bus_busy ? sel_live : 5'h00) : sel_q;
   assign o_select_n = ~sel_out;

   // arbitration pins only once enabled
   assign o_takeover_acknowledge_n = !(st_q == ST_HELD && hold_go);
   assign o_takeover_acknowledge_oe = arb_on_q && !is_slave;
   assign o_bus_request_out_n = !(arb_on_q && st_q == ST_HELD &&
                                  i_req_valid);
endmodule

// >>> dv/extbu_bus_asserts.sv
// port assertions for the external bus unit
`timescale 1ns/100ps
module extbu_bus_chk
   import extbu_pkg::*;
(
   // clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst,
   // configuration
   input wire logic i_arbitration_enable_bit,
   input wire logic i_arbitration_port_dir_bit7,
   input wire logic [1:0] i_seg_space,
   // observed outputs
   input wire logic [15:0] o_data_port_oe,
   input wire logic o_address_port_oe,
   input wire logic [7:0] o_segment_pins,
   input wire logic o_ale,
   input wire logic o_rd_n,
   input wire logic o_wr_n,
   input wire logic [4:0] o_select_n,
   input wire logic o_takeover_acknowledge_n,
   input wire logic o_takeover_acknowledge_oe,
   input wire logic o_bus_request_out_n
);
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   // a strobe in either direction marks the data phase
   wire strb = !o_rd_n || !o_wr_n;
   wire ack = o_takeover_acknowledge_oe && !o_takeover_acknowledge_n;
   // arbitration enable is sticky, so remember it was ever set
   logic arb_q;
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         arb_q <= 1'b0;
      end else begin
         arb_q <= arb_q | i_arbitration_enable_bit;
      end
   end
   sel_onehot_a: assert property ($onehot0(~o_select_n))
      else $error("two selects low at once");
   seg_64k_a: assert property (strb && i_seg_space == 2'h3 |->
      o_segment_pins == 8'h00) else $error("segment lines in 64k");
   seg_256k_a: assert property (strb && i_seg_space == 2'h2 |->
      o_segment_pins[7:2] == 6'h00) else $error("segment lines in 256k");
   seg_1m_a: assert property (strb && i_seg_space == 2'h1 |->
      o_segment_pins[7:4] == 4'h0) else $error("segment lines in 1m");
   ale_phase_a: assert property (o_ale |-> !strb)
      else $error("latch strobe in data phase");
   hold_float_a: assert property (ack |-> o_rd_n && o_wr_n &&
      !o_address_port_oe && !o_ale && o_data_port_oe == 16'h0000)
      else $error("bus driven while held");
   hold_finish_a: assert property ($fell(o_takeover_acknowledge_n) &&
      o_takeover_acknowledge_oe |-> $past(o_rd_n) && $past(o_wr_n))
      else $error("acknowledge cut a cycle");
   slave_in_a: assert property (i_arbitration_port_dir_bit7 [*3] |->
      !o_takeover_acknowledge_oe) else $error("ack driven in slave");
   arb_idle_a: assert property (!arb_q && !i_arbitration_enable_bit |->
      o_bus_request_out_n && !ack) else $error("arbitration early");
   cover property (ack);
   cover property (o_ale);
   cover property (!o_bus_request_out_n);
endmodule
bind extbu_top extbu_bus_chk i_extbu_bus_chk (.i_sys_clk, .i_rst,
   .i_arbitration_enable_bit, .i_arbitration_port_dir_bit7, .i_seg_space,
   .o_data_port_oe, .o_address_port_oe, .o_segment_pins, .o_ale,
   .o_rd_n, .o_wr_n,
   .o_select_n, .o_takeover_acknowledge_n, .o_takeover_acknowledge_oe,
   .o_bus_request_out_n);

// >>> dv/extbu_mem_model.sv
// memory or peripheral on the far side of the bus
`timescale 1ns/100ps
module extbu_mem_model #(
   parameter logic [15:0] RDATA = 16'ha5c3,
   parameter int SLOW_CYC = 6
) (
   // clock and strobes
   input wire logic i_clk,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   input wire logic i_ale,
   input wire logic i_slow,
   // data port as driven by the unit
   input wire logic [15:0] i_d,
   input wire logic [15:0] i_oe,
   // resolved pins and captured values
   output logic [15:0] o_d,
   output logic [15:0] o_addr,
   output logic [15:0] o_wdata,
   output logic o_ready_n
);
   // no pull-ups: a floating pin shows the inverse of its last level
   logic [15:0] last_q = 16'h0000;
   logic [3:0] cnt_q = 4'h0;
   always_comb begin
      for (int b = 0; b < 16; b++) begin
         o_d[b] = i_oe[b] ? i_d[b] : (!i_rd_n ? RDATA[b] : ~last_q[b]);
      end
   end
   // capture address phase and write data, count strobe length
   always_ff @(posedge i_clk) begin
      last_q <= o_d;
      o_addr <= i_ale ? i_d : o_addr;
      o_wdata <= !i_wr_n ? i_d : o_wdata;
      cnt_q <= (i_rd_n && i_wr_n) ? 4'h0 : cnt_q + {3'h0, cnt_q != 4'hf};
   end
   // slow device withholds ready for the first strobe cycles
   assign o_ready_n = i_slow && cnt_q < SLOW_CYC;
endmodule

// >>> dv/extbu_top_test.sv
// self-checking bench for the external bus unit
`timescale 1ns/100ps
module extbu_top_test
   import extbu_pkg::*;
;
   // bench state and unit connections
   logic i_sys_clk, i_rst, usel, arb_en, dir7, req_v, hold_n, slow;
   logic req_rdy, rsp_v, ext_f, ap_oe, ale, rd_n, wr_n, rdy_n;
   logic ack_n, ack_oe, bus_request_out_n, ack_in;
   logic [1:0] seg_sp;
   logic [4:0] sel_n, sel_seen;
   logic [7:0] seg, sg;
   logic [15:0] dp_in, dp_o, dp_oe, ap_o, ap, mdl_a, mdl_wd, rsp_d;
   extbu_cfg_t dcfg;
   extbu_cfg_t [3:0] wcfg;
   extbu_range_t [3:0] wrng;
   extbu_req_t req;
   int n_mismatch = 0, n_tests = 0, cyc = 0;
   // mode per select index: default, then windows one to four
   extbu_mode_t md [5] = '{EXTBU_DEMUX16, EXTBU_DEMUX16, EXTBU_MUX16,
      EXTBU_MUX8, EXTBU_DEMUX8};
   // window cases: enable mask, address, winning select
   logic [3:0] cm [5] = '{4'h3, 4'h1, 4'hc, 4'h4, 4'hf};
   logic [23:0] ca [5] = '{24'h010040, 24'h010040, 24'h020080,
      24'h020080, 24'h3a1234};
   int ci [5] = '{2, 1, 4, 3, 0};
   logic [7:0] sgx [4] = '{8'h3a, 8'h0a, 8'h02, 8'h00};
   extbu_top #(.NWIN(4)) i_extbu_top (.i_sys_clk, .i_rst,
      .i_default_bus_config_reg(dcfg), .i_window_bus_config_reg(wcfg),
      .i_window_range_reg(wrng), .i_unlatched_select_bit(usel),
      .i_arbitration_enable_bit(arb_en),
      .i_arbitration_port_dir_bit7(dir7), .i_seg_space(seg_sp),
      .i_data_port_dir(16'hff00), .i_data_port_gpio(16'h5a5a),
      .i_req_valid(req_v), .i_req(req), .o_req_ready(req_rdy),
      .o_rsp_valid(rsp_v), .o_rsp_data(rsp_d), .o_ext_fetch(ext_f),
      .i_data_port_pins(dp_in), .o_data_port_pins(dp_o),
      .o_data_port_oe(dp_oe), .o_address_port_pins(ap_o),
      .o_address_port_oe(ap_oe), .o_segment_pins(seg), .o_ale(ale),
      .o_rd_n(rd_n), .o_wr_n(wr_n), .i_ready_n(rdy_n),
      .i_external_fetch_select(1'b0), .o_select_n(sel_n),
      .i_hold_n(hold_n), .i_takeover_acknowledge_n(ack_in),
      .o_takeover_acknowledge_n(ack_n),
      .o_takeover_acknowledge_oe(ack_oe), .o_bus_request_out_n(bus_request_out_n));
   extbu_mem_model i_extbu_mem_model (.i_clk(i_sys_clk), .i_rd_n(rd_n),
      .i_wr_n(wr_n), .i_ale(ale), .i_slow(slow), .i_d(dp_o),
      .i_oe(dp_oe), .o_d(dp_in), .o_addr(mdl_a), .o_wdata(mdl_wd),
      .o_ready_n(rdy_n));
   initial begin
      i_sys_clk = 1'b0;
      forever #25 i_sys_clk = ~i_sys_clk;
   end
   // hang guard, well above the few hundred cycles the run needs
   always @(posedge i_sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim;
      end
   end
   task automatic tick;
      @(posedge i_sys_clk);
      #2;
   endtask
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim;
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   function automatic extbu_cfg_t cfg(input extbu_mode_t m);
      cfg = '{m, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
   endfunction
   // one access held until taken; returns data and cycles to answer
   task automatic acc(input logic [23:0] a, input logic [15:0] wd,
         input logic w, output logic [15:0] rd, output int n);
      int k;
      k = 0;
      n = 0;
      sel_seen = 5'h1f;
      req = '{a, wd, w};
      req_v = 1'b1;
      while (req_rdy !== 1'b1 && k < 60) begin
         tick;
         k++;
      end
      tick;
      req_v = 1'b0;
      while (rsp_v !== 1'b1 && n < 200) begin
         sel_seen &= sel_n;
         ap = strb_now() ? ap_o : ap;
         sg = strb_now() ? seg : sg;
         tick;
         n++;
      end
      chk({k < 60, n < 200}, 2'h3);
      rd = rsp_d;
      repeat (6) tick;
   endtask
   function automatic logic strb_now();
      strb_now = !rd_n || !wr_n;
   endfunction
   initial begin
      logic [15:0] rd;
      logic [4:0] es;
      extbu_mode_t m;
      int n0, n1, i;
      i_rst = 1'b1;
      {usel, arb_en, dir7, req_v, slow, seg_sp} = '0;
      hold_n = 1'b1;
      ack_in = 1'b1;
      req = '0;
      dcfg = cfg(EXTBU_DEMUX16);
      for (i = 0; i < 4; i++) begin
         wcfg[i] = cfg(md[i+1]);
         wrng[i] = '{(i < 2) ? 12'h010 : 12'h020, 4'h0};
      end
      repeat (8) @(posedge i_sys_clk);
      #2;
      i_rst = 1'b0;
      chk({ext_f, sel_n, bus_request_out_n}, 7'h7f);
      chk(dp_oe, 16'h00ff);
      // overlap priority, default region, each data path
      for (i = 0; i < 5; i++) begin
         for (int j = 0; j < 4; j++) wcfg[j].enable = cm[i][j];
         acc(ca[i], 16'h0000, 1'b0, rd, n0);
         es = ~(5'h01 << ci[i]);
         m = md[ci[i]];
         chk(sel_seen, es);
         chk(rd, (m == EXTBU_MUX8 || m == EXTBU_DEMUX8) ? 16'h00c3 :
            16'ha5c3);
         chk((m == EXTBU_MUX16 || m == EXTBU_MUX8) ? mdl_a : ap,
            ca[i][15:0]);
      end
      // upper address lines for each space size
      for (i = 0; i < 4; i++) begin
         seg_sp = i[1:0];
         usel = (i == 3);
         acc(24'h3a1234, 16'h0000, 1'b0, rd, n0);
         chk({sg, sel_seen}, {sgx[i], 5'h1e});
      end
      {seg_sp, usel} = '0;
      acc(24'h010040, 16'h1234, 1'b1, rd, n0);
      chk(mdl_wd, 16'h1234);
      acc(24'h020080, 16'h5678, 1'b1, rd, n0);
      chk(mdl_wd[7:0], 8'h78);
      // wait states and long latch strobe stretch the access
      acc(24'h010040, 16'h0000, 1'b0, rd, n0);
      wcfg[1].cycle_wait = 4'h3;
      acc(24'h010040, 16'h0000, 1'b0, rd, n1);
      chk(n1 - n0, 3);
      wcfg[1] = cfg(EXTBU_MUX16);
      wcfg[1].long_ale = 1'b1;
      acc(24'h010040, 16'h0000, 1'b0, rd, n1);
      chk(n1 - n0, 1);
      wcfg[1] = cfg(EXTBU_MUX16);
      wcfg[1].ready_en = 1'b1;
      acc(24'h010040, 16'h0000, 1'b0, rd, n0);
      slow = 1'b1;
      // let the withheld ready pass the input filter before the access
      repeat (6) tick;
      acc(24'h010040, 16'h0000, 1'b0, rd, n1);
      chk(n1 > n0 + 5, 1'b1);
      slow = 1'b0;
      // single chip: request is never answered
      dcfg = cfg(EXTBU_SINGLE);
      req = '{24'h3a1234, 16'h0000, 1'b0};
      req_v = 1'b1;
      n0 = 0;
      repeat (30) begin
         tick;
         req_v = 1'b0;
         n0 += (rsp_v === 1'b1);
      end
      chk(n0, 0);
      dcfg = cfg(EXTBU_DEMUX16);
      // hold while idle, then a request while held
      arb_en = 1'b1;
      hold_n = 1'b0;
      for (n0 = 0; ack_n !== 1'b0 && n0 < 30; n0++) tick;
      chk({ack_n, ack_oe, rd_n, dp_oe}, {3'h3, 16'h0000});
      fork
         acc(24'h3a1234, 16'h0000, 1'b0, rd, n1);
         begin
            for (n0 = 0; bus_request_out_n !== 1'b0 && n0 < 30; n0++) tick;
            chk({bus_request_out_n, rsp_v}, 2'h0);
            hold_n = 1'b1;
         end
      join
      chk(rd, 16'ha5c3);
      dir7 = 1'b1;
      repeat (4) tick;
      chk(ack_oe, 1'b0);
      // slave: acknowledge input low hands the bus away
      ack_in = 1'b0;
      repeat (6) tick;
      chk({req_rdy, dp_oe}, 17'h00000);
      end_sim;
   end
endmodule
